// [moc_pkg.sv]
/*
  Shared constants, register map and types for the motor overcurrent
  time element (second stage). Assumes a 50 MHz single clock domain.
*/
// Functional notes
// - averaging takes mean over configured cycle count
// - averaging switch selects averaged or raw current
// - stage works only with breaker aux input
// - pickup is setting, or 1.15x under IEC
// - timer advances only above operating setting
// - trip needs detection and expired timer
// - 200 ms reset timer against contact chatter
// - stage enable off keeps output inactive
// - operating current 200..2000 percent, step 2
// - time multiplier 4..240, step 1
// - curve select: long inverse or definite
// - locked rotor input switches to stage two
// - changeover delay 0.0..60.0 s, 0.1 s
// - definite time within 5 percent/50 ms
// - long inverse within table/100 ms
package moc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int RESET_MS = 200;
  localparam int RESET_TICKS = RESET_MS / TICK_MS;
  localparam int DT_MS_PER_K = 200;
  localparam int DT_TICKS_PER_K = DT_MS_PER_K / TICK_MS;
  // long inverse: t = 3 s * K / (I / 100 %), integrated per tick
  localparam int LI_MS_PCT_PER_K = 3000 * 100;
  localparam int LI_ACC_PER_K = LI_MS_PCT_PER_K / TICK_MS;
  localparam int LI_CLAMP_PCT = 2000;
  localparam int LR_STEP_MS = 100;
  localparam int LR_TICKS_PER_STEP = LR_STEP_MS / TICK_MS;

  localparam logic [10:0] PICK_MIN = 11'h0C8;
  localparam logic [10:0] PICK_MAX = 11'h7D0;
  localparam logic [7:0] KOCT_MIN = 8'h04;
  localparam logic [7:0] KOCT_MAX = 8'hF0;
  localparam logic [9:0] LRDLY_MAX = 10'h258;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PICK = 8'h04;
  localparam logic [7:0] OFS_KOCT = 8'h08;
  localparam logic [7:0] OFS_AVGN = 8'h0C;
  localparam logic [7:0] OFS_LRDLY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CUR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ST = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;

  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [5:0] AVGN_RST = 6'h01;
  localparam logic [9:0] LRDLY_RST = 10'h000;

  typedef struct packed {
    logic lr_en;
    logic curve_dt;
    logic iec_en;
    logic avg_en;
    logic stage_en;
  } moc_cfg_s;

  typedef struct packed {
    logic change;
    logic detect;
    logic trip;
  } moc_evt_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } moc_st_e;

  typedef logic [15:0] moc_cur_t;
endpackage : moc_pkg

// [moc_avg.sv]
/*
  Sliding mean of per-cycle current values over n cycles, with a serial
  divider. Assumes samples arrive far apart (one per power cycle).
*/
module moc_avg
  import moc_pkg::*;
#(
  parameter int W = 16,
  parameter int NW = 6,
  parameter int DEPTH = 64
)
(
  input wire logic clock, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic in_valid, // new cycle value
  input wire logic [W-1:0] in_val, // cycle value
  input wire logic [NW-1:0] n_cyc, // cycles to average, 0 acts as 1
  output logic out_valid, // mean ready pulse
  output logic [W-1:0] out_val // mean value
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = W + NW;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [NW-1:0] fill_r;
  logic [NW-1:0] n_eff;
  logic [NW-1:0] n_last_r;
  logic [SW-1:0] sum_r;
  logic [SW-1:0] quo_r;
  logic [NW-1:0] rem_r;
  logic [NW:0] rem_sh;
  logic ge;
  logic [4:0] cnt_r;
  logic busy_r;
  logic start_r;
  logic [W-1:0] old;

  assign n_eff = (n_cyc == '0) ? NW'(1) : n_cyc;
  assign old = mem[wp_r - AW'(n_eff)];
  assign rem_sh = {rem_r, quo_r[SW-1]};
  assign ge = rem_sh >= {1'b0, fill_r};

  always_ff @(posedge clock)
  begin
    if (in_valid)
      mem[wp_r] <= in_val;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn || n_eff != n_last_r)
    begin
      wp_r <= '0;
      fill_r <= '0;
      sum_r <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= in_valid;
      if (in_valid)
      begin
        wp_r <= wp_r + AW'(1);
        if (fill_r < n_eff)
        begin
          fill_r <= fill_r + NW'(1);
          sum_r <= sum_r + SW'(in_val);
        end
        else
          sum_r <= sum_r + SW'(in_val) - SW'(old);
      end
    end
    n_last_r <= resetn ? n_eff : NW'(1);
  end

  // divide by cycles held; early means use fewer cycles
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      quo_r <= '0;
      rem_r <= '0;
      out_valid <= 1'b0;
      out_val <= '0;
    end
    else
    begin
      out_valid <= 1'b0;
      if (start_r && fill_r != '0)
      begin
        busy_r <= 1'b1;
        cnt_r <= 5'(SW);
        quo_r <= sum_r;
        rem_r <= '0;
      end
      else if (busy_r)
      begin
        rem_r <= ge ? NW'(rem_sh - {1'b0, fill_r}) : rem_sh[NW-1:0];
        quo_r <= {quo_r[SW-2:0], ge};
        cnt_r <= cnt_r - 5'(1);
        if (cnt_r == 5'(1))
        begin
          busy_r <= 1'b0;
          out_valid <= 1'b1;
          out_val <= W'({quo_r[SW-2:0], ge});
        end
      end
    end
  end
endmodule : moc_avg

// [moc_oc2_elem.sv]
/*
  Second overcurrent stage of a motor relay: averaging select, pickup
  compare, long inverse / definite timer, reset timer, locked rotor
  changeover, register port and interrupt. Inputs are per-cycle current
  values in percent of rated current and two pin inputs.
*/
// Chosen here: the plain strobed port and the register offsets.
module moc_oc2_elem
  import moc_pkg::*;
#(
  parameter int TICK_CYC = moc_pkg::TICK_CYCLES,
  parameter int AVG_DEPTH = 64
)
(
  input wire logic clock, // 50 MHz
  input wire logic resetn, // sync reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic cur_valid, // one value per power cycle
  input wire moc_pkg::moc_cur_t cur_sample, // current, 1 % of rated
  input wire logic breaker_aux_input, // breaker aux contact pin
  input wire logic locked_rotor_input, // changeover request pin
  output logic detect, // detection output
  output logic trip, // stage operating output
  output logic stage2_active, // supervision on second stage
  output logic irq // level interrupt
);
  import moc_pkg::*;
  localparam int TW = $clog2(TICK_CYC);

  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic aux;
  logic lr;
  moc_cfg_s cfg_r;
  logic [10:0] pick_r;
  logic [7:0] koct_r;
  logic [5:0] avgn_r;
  logic [9:0] lrdly_r;
  moc_evt_s irq_st_r;
  moc_evt_s irq_en_r;
  moc_evt_s evt;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  logic avg_valid;
  moc_cur_t avg_val;
  moc_cur_t elem_r;
  logic [20:0] cur_x20;
  logic [20:0] set_x23;
  logic over_set;
  logic over_pick;
  logic operable;
  logic active;
  logic [23:0] acc_r;
  logic [23:0] limit;
  logic [23:0] inc;
  logic timer_done;
  moc_st_e st_r;
  moc_st_e st_nxt;
  logic [4:0] rst_cnt_r;
  logic hold_done;
  logic [12:0] lr_cnt_r;
  logic wr_clr;

  // pins cross in through two flops
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
    end
    else
    begin
      pin_s1_r <= {locked_rotor_input, breaker_aux_input};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign aux = pin_s2_r[0];
  assign lr = pin_s2_r[1];

  // settings are clamped on write so the timer never sees illegal values
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cfg_r <= CTRL_RST;
      pick_r <= PICK_MIN;
      koct_r <= KOCT_MIN;
      avgn_r <= AVGN_RST;
      lrdly_r <= LRDLY_RST;
      irq_en_r <= '0;
    end
    else if (wr)
    begin
      case (addr)
        OFS_CTRL: cfg_r <= wdata[4:0];
        OFS_PICK: pick_r <= (wdata < 32'(PICK_MIN)) ? PICK_MIN :
                            (wdata > 32'(PICK_MAX)) ? PICK_MAX : {wdata[10:1], 1'b0};
        OFS_KOCT: koct_r <= (wdata < 32'(KOCT_MIN)) ? KOCT_MIN :
                            (wdata > 32'(KOCT_MAX)) ? KOCT_MAX : wdata[7:0];
        OFS_AVGN: avgn_r <= wdata[5:0];
        OFS_LRDLY: lrdly_r <= (wdata > 32'(LRDLY_MAX)) ? LRDLY_MAX : wdata[9:0];
        OFS_IRQ_EN: irq_en_r <= wdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == TW'(TICK_CYC - 1))
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  moc_avg #(
    .W(16),
    .NW(6),
    .DEPTH(AVG_DEPTH)
  ) moc_avg_inst (
    .clock(clock),
    .resetn(resetn),
    .in_valid(cur_valid),
    .in_val(cur_sample),
    .n_cyc(avgn_r),
    .out_valid(avg_valid),
    .out_val(avg_val)
  );

  // averaged or raw value feeds the stage
  always_ff @(posedge clock)
  begin
    if (!resetn)
      elem_r <= '0;
    else if (cfg_r.avg_en && avg_valid)
      elem_r <= avg_val;
    else if (!cfg_r.avg_en && cur_valid)
      elem_r <= cur_sample;
  end

  assign cur_x20 = 21'(elem_r) * 21'(20);
  assign set_x23 = 21'(pick_r) * 21'(23);
  assign over_set = elem_r > 16'(pick_r);
  assign over_pick = cfg_r.iec_en ? (cur_x20 > set_x23) : over_set;
  assign operable = cfg_r.stage_en && aux && (!cfg_r.lr_en || stage2_active);
  // once tripped, only the pickup level keeps the output alive
  assign active = trip ? over_pick : over_set;

  // per-tick increment and limit per curve
  assign inc = cfg_r.curve_dt ? 24'(1) :
               (elem_r > 16'(LI_CLAMP_PCT)) ? 24'(LI_CLAMP_PCT) : 24'(elem_r);
  assign limit = cfg_r.curve_dt ? 24'(int'(koct_r) * DT_TICKS_PER_K) :
                 24'(int'(koct_r) * LI_ACC_PER_K);
  assign timer_done = acc_r >= limit;

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: if (active) st_nxt = ST_RUN;
      ST_RUN: if (!active) st_nxt = ST_HOLD;
      ST_HOLD:
      begin
        if (active)
          st_nxt = ST_RUN;
        else if (hold_done)
          st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!operable)
      st_nxt = ST_IDLE;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // reset timer counts ticks while dropped out
  assign hold_done = st_r == ST_HOLD && tick_r && rst_cnt_r == 5'(RESET_TICKS - 1);
  always_ff @(posedge clock)
  begin
    if (!resetn || st_r != ST_HOLD || active)
      rst_cnt_r <= '0;
    else if (tick_r)
      rst_cnt_r <= rst_cnt_r + 5'(1);
  end

  // tick-granular integrator, error under one tick
  always_ff @(posedge clock)
  begin
    if (!resetn || !operable || hold_done)
      acc_r <= '0;
    else if (tick_r && over_set && !timer_done)
      acc_r <= acc_r + inc;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      trip <= 1'b0;
      detect <= 1'b0;
    end
    else
    begin
      detect <= operable && over_pick;
      if (!operable || hold_done)
        trip <= 1'b0;
      else if (over_pick && timer_done)
        trip <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn || !lr)
    begin
      lr_cnt_r <= '0;
      stage2_active <= 1'b0;
    end
    else if (!stage2_active)
    begin
      if (lr_cnt_r >= 13'(int'(lrdly_r) * LR_TICKS_PER_STEP))
        stage2_active <= 1'b1;
      else if (tick_r)
        lr_cnt_r <= lr_cnt_r + 13'(1);
    end
  end

  assign evt.trip = operable && !hold_done && over_pick && timer_done && !trip;
  assign evt.detect = operable && over_pick && !detect;
  assign evt.change = lr && !stage2_active &&
                      lr_cnt_r >= 13'(int'(lrdly_r) * LR_TICKS_PER_STEP);
  assign wr_clr = wr && addr == OFS_IRQ_CLR;

  // new events win over a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      irq_st_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~(wr_clr ? moc_evt_s'(wdata[2:0]) : '0)) | evt;
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn || !rd)
      rdata <= '0;
    else
    begin
      case (addr)
        OFS_CTRL: rdata <= 32'(cfg_r);
        OFS_PICK: rdata <= 32'(pick_r);
        OFS_KOCT: rdata <= 32'(koct_r);
        OFS_AVGN: rdata <= 32'(avgn_r);
        OFS_LRDLY: rdata <= 32'(lrdly_r);
        OFS_STATUS: rdata <= 32'({lr, aux, stage2_active, trip, detect, st_r});
        OFS_CUR: rdata <= 32'(elem_r);
        OFS_IRQ_ST: rdata <= 32'(irq_st_r);
        OFS_IRQ_EN: rdata <= 32'(irq_en_r);
        default: rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_avg_sel;
    cur_valid && !cfg_r.avg_en |=> elem_r == $past(cur_sample);
  endproperty
  a_avg_sel: assert property (p_avg_sel) else $error("raw current not taken");

  property p_aux_gate;
    !aux |=> !trip && acc_r == '0 && !detect;
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("stage live without aux");

  property p_iec_pick;
    cfg_r.iec_en && cur_x20 <= set_x23 |=> !detect;
  endproperty
  a_iec_pick: assert property (p_iec_pick) else $error("detect below 1.15x");

  property p_timer_adv;
    acc_r > $past(acc_r) |-> $past(tick_r && over_set && operable);
  endproperty
  a_timer_adv: assert property (p_timer_adv) else $error("timer moved wrongly");

  property p_trip_cause;
    $rose(trip) |-> $past(over_pick && timer_done && operable);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip without cause");

  property p_hold;
    $fell(trip) |-> $past(!operable || (hold_done && rst_cnt_r == 5'(RESET_TICKS - 1)));
  endproperty
  a_hold: assert property (p_hold) else $error("trip dropped early");

  property p_enable;
    !cfg_r.stage_en |=> !trip && !detect;
  endproperty
  a_enable: assert property (p_enable) else $error("output while disabled");

  property p_pick_rng;
    pick_r >= PICK_MIN && pick_r <= PICK_MAX && !pick_r[0];
  endproperty
  a_pick_rng: assert property (p_pick_rng) else $error("pickup out of range");

  property p_koct_rng;
    koct_r >= KOCT_MIN && koct_r <= KOCT_MAX;
  endproperty
  a_koct_rng: assert property (p_koct_rng) else $error("multiplier out of range");

  property p_dt_step;
    cfg_r.curve_dt && tick_r && over_set && operable && !timer_done && !hold_done
      |=> acc_r == $past(acc_r) + 24'(1);
  endproperty
  a_dt_step: assert property (p_dt_step) else $error("definite step wrong");

  property p_lr_back;
    !lr |=> !stage2_active;
  endproperty
  a_lr_back: assert property (p_lr_back) else $error("stage two kept");

  property p_tick;
    tick_r |=> !tick_r;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");

  c_trip: cover property ($rose(trip));
  c_hold_clear: cover property (st_r == ST_HOLD ##1 st_r == ST_IDLE);
  c_change: cover property ($rose(stage2_active));
  c_iec_zone: cover property (cfg_r.iec_en && over_set && !over_pick);
endmodule : moc_oc2_elem

// [moc_oc2_elem_tb.sv]
/*
  Self-checking bench for the second overcurrent stage element.
  Assumes a 50-cycle tick parameter, so every timer count stays short.
*/
module moc_oc2_elem_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import moc_pkg::*;
  localparam int TK = 50;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic cur_valid = 1'b0;
  moc_cur_t cur_sample = 16'h0000;
  logic breaker_aux_input = 1'b0;
  logic locked_rotor_input = 1'b0;
  logic detect;
  logic trip;
  logic stage2_active;
  logic irq;
  int failures = 0;
  int checked = 0;
  int seed = 32'h8141;
  int cnt = 0;
  logic [15:0] level = 16'h0000;
  logic [31:0] got;
  logic [15:0] sm [6];
  event fed;

  moc_oc2_elem #(.TICK_CYC(TK), .AVG_DEPTH(64)) moc_oc2_elem_inst (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cur_valid(cur_valid), .cur_sample(cur_sample),
    .breaker_aux_input(breaker_aux_input), .locked_rotor_input(locked_rotor_input),
    .detect(detect), .trip(trip), .stage2_active(stage2_active), .irq(irq));

  always #10 clock = ~clock;

  // one value per 40 cycles, safely above the minimum sample spacing
  always @(posedge clock)
  begin
    cnt <= (cnt == 39) ? 0 : cnt + 1;
    cur_valid <= (cnt == 39);
    if (cnt == 39)
    begin
      cur_sample <= level;
      -> fed;
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic check_pin(input logic g, input logic e);
    check({31'h0, g}, {31'h0, e});
  endtask : check_pin

  // ends just past the edge so outputs have settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1;
    got = rdata;
    check(got & m, e);
  endtask : rd_chk

  // new level is taken by the next sample pulse
  task automatic push(input logic [15:0] v);
    @(fed);
    level = v;
  endtask : push

  task automatic set_pin(input int which, input logic v);
    @(posedge clock);
    if (which == 0)
      breaker_aux_input <= v;
    else
      locked_rotor_input <= v;
  endtask : set_pin

  function automatic logic [31:0] mean_last4();
    logic [31:0] s;
    s = 32'h0;
    for (int i = 2; i < 6; i++)
      s = s + {16'h0, sm[i]};
    return s / 4;
  endfunction : mean_last4

  initial
  begin
    #1_200_000;
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rd_chk(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(OFS_PICK, 32'hFFFFFFFF, 32'h00C8);
    rd_chk(OFS_KOCT, 32'hFFFFFFFF, 32'h0004);
    rd_chk(OFS_AVGN, 32'hFFFFFFFF, 32'h0001);
    rd_chk(OFS_LRDLY, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h30, 32'hFFFFFFFF, 32'h0);
    wr_reg(OFS_PICK, 32'h0BB8);
    rd_chk(OFS_PICK, 32'hFFFFFFFF, 32'h07D0);
    wr_reg(OFS_KOCT, 32'h00FA);
    rd_chk(OFS_KOCT, 32'hFFFFFFFF, 32'h00F0);
    wr_reg(OFS_LRDLY, 32'h02BC);
    rd_chk(OFS_LRDLY, 32'hFFFFFFFF, 32'h0258);
    wr_reg(OFS_PICK, 32'h012C);
    wr_reg(OFS_KOCT, 32'h0004);
    wr_reg(OFS_CTRL, 32'h0009);
    level = 16'h01F4;
    wait_cyc(85 * TK);
    check_pin(trip, 1'b0);
    wr_reg(OFS_CTRL, 32'h0008);
    set_pin(0, 1'b1);
    wait_cyc(85 * TK);
    check_pin(trip, 1'b0);
    check_pin(detect, 1'b0);
    wr_reg(OFS_IRQ_EN, 32'h0001);
    wr_reg(OFS_CTRL, 32'h0009);
    wait_cyc(76 * TK);
    check_pin(trip, 1'b0);
    check_pin(detect, 1'b1);
    wait_cyc(8 * TK);
    check_pin(trip, 1'b1);
    check_pin(irq, 1'b1);
    rd_chk(OFS_STATUS, 32'h0010, 32'h0010);
    wr_reg(OFS_IRQ_EN, 32'h0);
    wait_cyc(2);
    check_pin(irq, 1'b0);
    rd_chk(OFS_IRQ_ST, 32'h0003, 32'h0003);
    wr_reg(OFS_IRQ_CLR, 32'h0007);
    rd_chk(OFS_IRQ_ST, 32'h0003, 32'h0);
    level = 16'h0064;
    wait_cyc(18 * TK);
    check_pin(trip, 1'b1);
    wait_cyc(5 * TK);
    check_pin(trip, 1'b0);
    // a timer left running would trip at once here
    level = 16'h01F4;
    wait_cyc(40 * TK);
    check_pin(trip, 1'b0);
    level = 16'h0064;
    wait_cyc(23 * TK);
    wr_reg(OFS_CTRL, 32'h000D);
    level = 16'h014A;
    wait_cyc(2 * TK);
    check_pin(detect, 1'b0);
    level = 16'h015E;
    wait_cyc(2 * TK);
    check_pin(detect, 1'b1);
    level = 16'h0064;
    wait_cyc(23 * TK);
    wr_reg(OFS_CTRL, 32'h0001);
    level = 16'h07D0;
    wait_cyc(56 * TK);
    check_pin(trip, 1'b0);
    wait_cyc(8 * TK);
    check_pin(trip, 1'b1);
    set_pin(0, 1'b0);
    wait_cyc(5);
    check_pin(trip, 1'b0);
    set_pin(0, 1'b1);
    wr_reg(OFS_CTRL, 32'h0003);
    wr_reg(OFS_AVGN, 32'h0004);
    for (int i = 0; i < 6; i++)
    begin
      sm[i] = 16'($unsigned($random(seed)) % 2001);
      push(sm[i]);
    end
    @(fed);
    wait_cyc(28);
    rd_chk(OFS_CUR, 32'hFFFFFFFF, mean_last4());
    wr_reg(OFS_CTRL, 32'h0001);
    push(16'h0123);
    @(fed);
    wait_cyc(3);
    rd_chk(OFS_CUR, 32'hFFFFFFFF, 32'h0123);
    level = 16'h0064;
    wr_reg(OFS_CTRL, 32'h0011);
    wr_reg(OFS_LRDLY, 32'h0002);
    wr_reg(OFS_IRQ_EN, 32'h0004);
    set_pin(1, 1'b1);
    wait_cyc(18 * TK);
    check_pin(stage2_active, 1'b0);
    wait_cyc(4 * TK);
    check_pin(stage2_active, 1'b1);
    check_pin(irq, 1'b1);
    wr_reg(OFS_IRQ_CLR, 32'h0004);
    wait_cyc(2);
    check_pin(irq, 1'b0);
    set_pin(1, 1'b0);
    wait_cyc(5);
    check_pin(stage2_active, 1'b0);
    end_of_test();
  end
endmodule : moc_oc2_elem_tb
